// ---- lsf_defines.svh ----
`ifndef LSF_DEFINES_SVH
`define LSF_DEFINES_SVH

// command bytes
`define LSF_CMD_LOOP_WR 8'hC2
`define LSF_CMD_LOOP_RD 8'hC3
`define LSF_CMD_FEED_WR 8'hC6
`define LSF_CMD_FEED_RD 8'hC7
`define LSF_CMD_GAIN_WR 8'hCA
`define LSF_CMD_GAIN_RD 8'hCB
`define LSF_CMD_SAMPLE_RD 8'hCD

// data byte counts per command
`define LSF_LOOP_BYTES 3'd4
`define LSF_FEED_BYTES 3'd2
`define LSF_GAIN_BYTES 3'd1
`define LSF_SAMPLE_BYTES 3'd2

// reset values
`define LSF_LOOP_RESET 32'h1B84_B30E
`define LSF_FEED_RESET 16'h1108
`define LSF_GAIN_RESET 8'h00
`define LSF_SAMPLE_RESET 16'h0000

// defined-bit masks, reserved bits stored as zero
`define LSF_LOOP_MASK 32'h3FFF_FF1F
`define LSF_FEED_MASK 16'h7FDF

// loop supervision field positions (lsb)
`define LSF_GFT_LSB 27
`define LSF_OHT_LSB 24
`define LSF_GFD_LSB 21
`define LSF_OHD_LSB 16
`define LSF_RTM_BIT 15
`define LSF_RTT_LSB 8
`define LSF_RCL_LSB 0

// dc feed field positions (lsb)
`define LSF_SHIFT_BIT 14
`define LSF_LEG_BIT 13
`define LSF_VOC_LSB 10
`define LSF_VAS_LSB 6
`define LSF_ILA_LSB 0

`endif

// ---- lsf_pkg.sv ----
package lsf_pkg;

    typedef enum logic [1:0] {
        LSF_ST_CMD = 2'b00,
        LSF_ST_WR = 2'b01,
        LSF_ST_RD = 2'b10,
        LSF_ST_SKIP = 2'b11
    } lsf_state_e;

endpackage : lsf_pkg

// ---- lsf_line_supervision_feed_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - loop block: write C2h, read C3h, four data bytes after command
// - host writes reserved bits zero; they read back as zero here
// - ground-key threshold, three bits, 6 mA per code, default 011b
// - switch-hook threshold, three bits, 8 to 15 mA, default 011b
// - ground-key debounce, three bits, 4 ms per code, default 100b
// - switch-hook debounce, five bits, 2 ms per code, default 00100b
// - ring-trip method: 0 dc detection, 1 ac detection, set at reset
// - ring-trip threshold, seven bits, 0.5 mA per code
// - ringing current limit, five bits, 50 to 112 mA, default 01110b
// - feed block: write C6h, read C7h, two bytes, resets 1108h
// - feed voltage three bits, 3 V steps, range shifted by shift bit
// - leg impedance bit: 0 is 100 ohm per leg, 1 is 50 ohm
// - anti-saturation offset, four bits, 0.75 V steps
// - active current limit, five bits, 18 to 49 mA
// - gain register CAh, eight-bit two's complement, zero bypasses
// - Transmit_sample_readout reads two-byte sample when buffer mode clear; resets zero
// - companded: code in upper byte; linear: full sixteen bits
// - sample from the one enabled channel, else channel 1
// - test mode sample passes converter value in 1.15 format
// - sample updates at converter rate; armed update flags data ready
// - sample also goes to pcm transmit on every strobe; cut path set drops only the valid pulse
`include "lsf_defines.svh"

module lsf_line_supervision_feed_regs (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_mpi_clk,
    input wire logic i_mpi_cs_n,
    input wire logic i_mpi_din,
    output logic o_mpi_dout,
    output logic o_mpi_dout_oe_n,
    input wire logic [15:0] i_ch1_sample,
    input wire logic [15:0] i_ch2_sample,
    input wire logic i_sample_strobe,
    input wire logic i_linear_mode,
    input wire logic [1:0] i_channel_enable,
    input wire logic i_test_buffer_mode,
    input wire logic i_transmit_interrupt_arm,
    input wire logic i_cut_transmit_path,
    output logic [2:0] o_ground_fault_threshold,
    output logic [2:0] o_offhook_threshold,
    output logic [2:0] o_ground_fault_debounce,
    output logic [4:0] o_offhook_debounce,
    output logic o_ring_trip_method,
    output logic [6:0] o_ring_trip_threshold,
    output logic [4:0] o_ringing_current_limit,
    output logic o_feed_voltage_range_shift,
    output logic o_leg_impedance_select,
    output logic [2:0] o_open_circuit_feed_voltage,
    output logic [3:0] o_anti_saturation_offset,
    output logic [4:0] o_active_current_limit,
    output logic [7:0] o_impedance_scaling_gain,
    output logic [15:0] o_transmit_sample,
    output logic o_data_ready_flag,
    output logic [15:0] o_pcm_transmit_output,
    output logic o_pcm_transmit_valid
);

    logic [2:0] clk_sync;
    logic [1:0] cs_sync;
    logic [1:0] din_sync;
    logic clk_rise;
    logic clk_fall;
    logic cs_act;

    lsf_pkg::lsf_state_e state;
    logic [2:0] bit_cnt;
    logic [2:0] bytes_left;
    logic [7:0] cur_cmd;
    logic [7:0] in_byte;
    logic [7:0] next_in_byte;
    logic byte_done;
    logic [31:0] wr_shift;
    logic [31:0] next_wr_shift;
    logic [31:0] rd_shift;
    logic [31:0] rd_load;
    logic [2:0] cmd_bytes;
    logic cmd_is_read;
    logic cmd_known;

    logic [31:0] loop_params;
    logic [15:0] feed_params;
    logic [7:0] gain;
    logic [15:0] sample;
    logic [15:0] picked;
    logic [15:0] formatted;

    // pins are asynchronous to i_ref_clk; the second stage is read, and for the clock the third stage as well
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            clk_sync <= 3'b000;
            cs_sync <= 2'b11;
            din_sync <= 2'b00;
        end
        else
        begin
            clk_sync <= {clk_sync[1:0], i_mpi_clk};
            cs_sync <= {cs_sync[0], i_mpi_cs_n};
            din_sync <= {din_sync[0], i_mpi_din};
        end
    end

    assign cs_act = ~cs_sync[1];
    assign clk_rise = cs_act & clk_sync[1] & ~clk_sync[2];
    assign clk_fall = cs_act & ~clk_sync[1] & clk_sync[2];
    assign next_in_byte = {in_byte[6:0], din_sync[1]};
    assign byte_done = clk_rise & (bit_cnt == 3'd7);
    assign next_wr_shift = {wr_shift[23:0], next_in_byte};

    // command decode: data length, direction and the value to shift out
    always_comb
    begin
        cmd_bytes = 3'd0;
        cmd_is_read = 1'b0;
        cmd_known = 1'b1;
        rd_load = 32'h0000_0000;
        unique case (next_in_byte)
            `LSF_CMD_LOOP_WR:
            begin
                cmd_bytes = `LSF_LOOP_BYTES;
            end
            `LSF_CMD_LOOP_RD:
            begin
                cmd_bytes = `LSF_LOOP_BYTES;
                cmd_is_read = 1'b1;
                rd_load = loop_params;
            end
            `LSF_CMD_FEED_WR:
            begin
                cmd_bytes = `LSF_FEED_BYTES;
            end
            `LSF_CMD_FEED_RD:
            begin
                cmd_bytes = `LSF_FEED_BYTES;
                cmd_is_read = 1'b1;
                rd_load = {feed_params, 16'h0000};
            end
            `LSF_CMD_GAIN_WR:
            begin
                cmd_bytes = `LSF_GAIN_BYTES;
            end
            `LSF_CMD_GAIN_RD:
            begin
                cmd_bytes = `LSF_GAIN_BYTES;
                cmd_is_read = 1'b1;
                rd_load = {gain, 24'h00_0000};
            end
            `LSF_CMD_SAMPLE_RD:
            begin
                cmd_bytes = `LSF_SAMPLE_BYTES;
                cmd_is_read = 1'b1;
                // buffer mode hands this command to the fifo; read zero here
                if (!i_test_buffer_mode)
                begin
                    rd_load = {sample, 16'h0000};
                end
            end
            default:
            begin
                cmd_known = 1'b0;
            end
        endcase
    end

    // bit and byte framing; bit count restarts whenever chip select lifts
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_cnt <= 3'd0;
            in_byte <= 8'h00;
        end
        else if (!cs_act)
        begin
            bit_cnt <= 3'd0;
        end
        else if (clk_rise)
        begin
            bit_cnt <= bit_cnt + 3'd1;
            in_byte <= next_in_byte;
        end
    end

    // command state machine; unknown commands are taken as no-data
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= lsf_pkg::LSF_ST_CMD;
            bytes_left <= 3'd0;
            cur_cmd <= 8'h00;
            wr_shift <= 32'h0000_0000;
        end
        else if (byte_done)
        begin
            unique case (state)
                lsf_pkg::LSF_ST_CMD:
                begin
                    cur_cmd <= next_in_byte;
                    bytes_left <= cmd_bytes;
                    wr_shift <= 32'h0000_0000;
                    if (!cmd_known)
                    begin
                        state <= lsf_pkg::LSF_ST_CMD;
                    end
                    else if (cmd_is_read)
                    begin
                        state <= lsf_pkg::LSF_ST_RD;
                    end
                    else
                    begin
                        state <= lsf_pkg::LSF_ST_WR;
                    end
                end
                lsf_pkg::LSF_ST_WR,
                lsf_pkg::LSF_ST_RD,
                lsf_pkg::LSF_ST_SKIP:
                begin
                    wr_shift <= next_wr_shift;
                    bytes_left <= bytes_left - 3'd1;
                    if (bytes_left == 3'd1)
                    begin
                        state <= lsf_pkg::LSF_ST_CMD;
                    end
                end
            endcase
        end
    end

    // the write commits only on the last byte; a cut-off write stays pending until the bytes still owed, sent later, complete it
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            loop_params <= `LSF_LOOP_RESET;
            feed_params <= `LSF_FEED_RESET;
            gain <= `LSF_GAIN_RESET;
        end
        else if (byte_done && state == lsf_pkg::LSF_ST_WR &&
            bytes_left == 3'd1)
        begin
            if (cur_cmd == `LSF_CMD_LOOP_WR)
            begin
                loop_params <= next_wr_shift & `LSF_LOOP_MASK;
            end
            if (cur_cmd == `LSF_CMD_FEED_WR)
            begin
                feed_params <= next_wr_shift[15:0] &
                    `LSF_FEED_MASK;
            end
            if (cur_cmd == `LSF_CMD_GAIN_WR)
            begin
                gain <= next_wr_shift[7:0];
            end
        end
    end

    // read data: loaded at the command byte, new bit on each falling clock
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_shift <= 32'h0000_0000;
            o_mpi_dout <= 1'b0;
            o_mpi_dout_oe_n <= 1'b1;
        end
        else
        begin
            if (byte_done && state == lsf_pkg::LSF_ST_CMD)
            begin
                rd_shift <= rd_load;
            end
            else if (clk_fall && state == lsf_pkg::LSF_ST_RD)
            begin
                o_mpi_dout <= rd_shift[31];
                rd_shift <= {rd_shift[30:0], 1'b0};
            end
            o_mpi_dout_oe_n <= ~(cs_act && state == lsf_pkg::LSF_ST_RD);
        end
    end

    // channel 2 only when it alone is enabled
    assign picked = (i_channel_enable == 2'b10) ?
        i_ch2_sample : i_ch1_sample;
    // linear and test data pass whole; companded keeps the upper byte
    assign formatted = i_linear_mode ? picked :
        {picked[15:8], 8'h00};

    // sample register and its side effects follow the converter strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sample <= `LSF_SAMPLE_RESET;
            o_data_ready_flag <= 1'b0;
            o_pcm_transmit_output <= 16'h0000;
            o_pcm_transmit_valid <= 1'b0;
        end
        else
        begin
            if (i_sample_strobe)
            begin
                sample <= formatted;
                o_pcm_transmit_output <= formatted;
            end
            o_data_ready_flag <= i_sample_strobe &
                i_transmit_interrupt_arm;
            o_pcm_transmit_valid <= i_sample_strobe &
                ~i_cut_transmit_path;
        end
    end

    // field outputs straight from the parameter flip-flops
    assign o_ground_fault_threshold =
        loop_params[`LSF_GFT_LSB +: 3];
    assign o_offhook_threshold =
        loop_params[`LSF_OHT_LSB +: 3];
    assign o_ground_fault_debounce =
        loop_params[`LSF_GFD_LSB +: 3];
    // codes below 6 ms are accepted; avoiding them is the host's call
    assign o_offhook_debounce =
        loop_params[`LSF_OHD_LSB +: 5];
    assign o_ring_trip_method = loop_params[`LSF_RTM_BIT];
    assign o_ring_trip_threshold =
        loop_params[`LSF_RTT_LSB +: 7];
    assign o_ringing_current_limit =
        loop_params[`LSF_RCL_LSB +: 5];
    assign o_feed_voltage_range_shift =
        feed_params[`LSF_SHIFT_BIT];
    assign o_leg_impedance_select =
        feed_params[`LSF_LEG_BIT];
    assign o_open_circuit_feed_voltage =
        feed_params[`LSF_VOC_LSB +: 3];
    assign o_anti_saturation_offset =
        feed_params[`LSF_VAS_LSB +: 4];
    assign o_active_current_limit =
        feed_params[`LSF_ILA_LSB +: 5];
    assign o_impedance_scaling_gain = gain;
    assign o_transmit_sample = sample;

endmodule : lsf_line_supervision_feed_regs

// ---- lsf_checker_assertions.sv ----
`timescale 1ns/1ps
module lsf_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_mpi_cs_n,
    input wire logic [15:0] i_ch1_sample,
    input wire logic [15:0] i_ch2_sample,
    input wire logic i_sample_strobe,
    input wire logic i_linear_mode,
    input wire logic [1:0] i_channel_enable,
    input wire logic i_transmit_interrupt_arm,
    input wire logic i_cut_transmit_path,
    input wire logic o_mpi_dout_oe_n,
    input wire logic [4:0] o_offhook_debounce,
    input wire logic [7:0] o_impedance_scaling_gain,
    input wire logic [15:0] o_transmit_sample,
    input wire logic o_data_ready_flag,
    input wire logic [15:0] o_pcm_transmit_output,
    input wire logic o_pcm_transmit_valid
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // a settled idle port: synchroniser flushed; the state register keeps its value
    sequence s_port_idle;
        i_mpi_cs_n [*6];
    endsequence
    sequence s_strobe_lin(logic [1:0] sel);
        i_sample_strobe && i_linear_mode && i_channel_enable == sel;
    endsequence
    AST_READY: assert property (
        i_sample_strobe && i_transmit_interrupt_arm |=> o_data_ready_flag)
        else $error("ready pulse missing");
    AST_READY_CAUSE: assert property (
        o_data_ready_flag |->
        $past(i_sample_strobe && i_transmit_interrupt_arm))
        else $error("ready pulse without armed strobe");
    AST_VALID: assert property (
        i_sample_strobe |=>
        o_pcm_transmit_valid == !$past(i_cut_transmit_path))
        else $error("pcm valid wrong");
    AST_PCM_DATA: assert property (
        i_sample_strobe && !i_cut_transmit_path |=>
        o_pcm_transmit_output == o_transmit_sample)
        else $error("pcm data differs from sample");
    AST_CH2: assert property (
        s_strobe_lin(2'b10) |=> o_transmit_sample == $past(i_ch2_sample))
        else $error("channel 2 sample wrong");
    AST_CH1: assert property (
        s_strobe_lin(2'b01) or s_strobe_lin(2'b11) or s_strobe_lin(2'b00)
        |=> o_transmit_sample == $past(i_ch1_sample))
        else $error("channel 1 sample wrong");
    AST_COMPANDED: assert property (
        i_sample_strobe && !i_linear_mode |=> o_transmit_sample[7:0] == 8'h00)
        else $error("companded lower byte not zero");
    AST_HOLD: assert property (
        !i_sample_strobe |=> $stable(o_transmit_sample))
        else $error("sample changed without strobe");
    AST_OE_IDLE: assert property (
        s_port_idle |-> o_mpi_dout_oe_n)
        else $error("dout driven while deselected");
    // dout may only be driven three cycles after chip select went low
    AST_OE_CAUSE: assert property (
        !o_mpi_dout_oe_n |-> $past(!i_mpi_cs_n, 3))
        else $error("dout driven without chip select");
    AST_REG_STABLE: assert property (
        s_port_idle |=>
        $stable(o_offhook_debounce) && $stable(o_impedance_scaling_gain))
        else $error("register changed while deselected");
endmodule : lsf_checker

// ---- lsf_host_model.sv ----
`timescale 1ns/1ps
module lsf_host_model (
    input wire logic i_ref_clk,
    input wire logic i_mpi_dout,
    output logic o_mpi_clk,
    output logic o_mpi_cs_n,
    output logic o_mpi_din
);
    initial
    begin
        o_mpi_clk = 1'b1;
        o_mpi_cs_n = 1'b1;
        o_mpi_din = 1'b0;
    end
    // command byte then n data bytes, msb first; callers pass reserved
    // bits as zero and debounce codes of 6 ms or more
    task automatic xfer(input logic [7:0] cmd, input int n,
        input logic [31:0] wd, output logic [31:0] rd);
        logic [39:0] sh;
        int i;
        sh = {cmd, wd << (8 * (4 - n))};
        rd = 32'h0000_0000;
        @(posedge i_ref_clk);
        o_mpi_cs_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        for (i = 0; i < 8 * (n + 1); i++)
        begin
            o_mpi_clk <= 1'b0;
            o_mpi_din <= sh[39];
            sh = sh << 1;
            repeat (5) @(posedge i_ref_clk);
            if (i >= 8)
                rd = {rd[30:0], i_mpi_dout};
            o_mpi_clk <= 1'b1;
            repeat (5) @(posedge i_ref_clk);
        end
        // released line shows the inverse so a stale bit cannot pass
        o_mpi_cs_n <= 1'b1;
        o_mpi_din <= ~o_mpi_din;
        repeat (8) @(posedge i_ref_clk);
    endtask : xfer
endmodule : lsf_host_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] c1, c2;
        logic lin;
        logic [1:0] en;
        logic arm, cut;
        logic [15:0] exp;
        logic rdy, vld;
    } lsf_row_s;
    logic clk = 0, rst_n = 0, sck, cs_n, din, dout, oe_n, stb = 0, lin = 0;
    logic [15:0] c1 = 0, c2 = 0, smp, pcm;
    logic [1:0] en = 0;
    logic tbm = 0, arm = 0, cut = 0, rdy, vld, rtm, sft, leg;
    logic [2:0] gft, oht, gfd, open_circuit_feed_voltage;
    logic [4:0] ohd, rcl, active_current_limit;
    logic [6:0] rtt;
    logic [3:0] anti_saturation_offset;
    logic [7:0] gain;
    logic [31:0] rd;
    int mismatches = 0, n_tests = 0, cyc = 0;
    wire [31:0] loop_w = {2'b00, gft, oht, gfd, ohd, rtm, rtt, 3'b000, rcl};
    wire [15:0] feed_w = {1'b0, sft, leg, open_circuit_feed_voltage, anti_saturation_offset, 1'b0, active_current_limit};
    lsf_row_s rows [5] = '{
        '{16'h1234, 16'hABCD, 1'b1, 2'b01, 1'b1, 1'b0, 16'h1234, 1'b1, 1'b1},
        '{16'h5A5A, 16'hABCD, 1'b1, 2'b10, 1'b0, 1'b1, 16'hABCD, 1'b0, 1'b0},
        '{16'h8001, 16'h7FFF, 1'b1, 2'b11, 1'b1, 1'b0, 16'h8001, 1'b1, 1'b1},
        '{16'h0F0F, 16'h7FFF, 1'b1, 2'b00, 1'b0, 1'b0, 16'h0F0F, 1'b0, 1'b1},
        '{16'h0F0F, 16'hABCD, 1'b0, 2'b10, 1'b1, 1'b0, 16'hAB00, 1'b1, 1'b1}};
    initial
    begin
        forever #10 clk = ~clk;
    end
    lsf_line_supervision_feed_regs u_lsf_line_supervision_feed_regs (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_mpi_clk(sck),
        .i_mpi_cs_n(cs_n), .i_mpi_din(din), .o_mpi_dout(dout),
        .o_mpi_dout_oe_n(oe_n), .i_ch1_sample(c1), .i_ch2_sample(c2),
        .i_sample_strobe(stb), .i_linear_mode(lin),
        .i_channel_enable(en), .i_test_buffer_mode(tbm),
        .i_transmit_interrupt_arm(arm), .i_cut_transmit_path(cut),
        .o_ground_fault_threshold(gft), .o_offhook_threshold(oht),
        .o_ground_fault_debounce(gfd), .o_offhook_debounce(ohd),
        .o_ring_trip_method(rtm), .o_ring_trip_threshold(rtt),
        .o_ringing_current_limit(rcl), .o_feed_voltage_range_shift(sft),
        .o_leg_impedance_select(leg), .o_open_circuit_feed_voltage(open_circuit_feed_voltage),
        .o_anti_saturation_offset(anti_saturation_offset), .o_active_current_limit(active_current_limit),
        .o_impedance_scaling_gain(gain), .o_transmit_sample(smp),
        .o_data_ready_flag(rdy), .o_pcm_transmit_output(pcm),
        .o_pcm_transmit_valid(vld));
    lsf_host_model u_lsf_host_model (.i_ref_clk(clk), .i_mpi_dout(dout),
        .o_mpi_clk(sck), .o_mpi_cs_n(cs_n), .o_mpi_din(din));
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic reset_check();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        chk("loop reset", 32'h1B84_B30E,
            loop_w);
        chk("feed reset", 32'h1108,
            feed_w);
        chk("gain reset", 32'h00, gain);
        chk("sample reset", 32'h0000, smp);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : reset_check
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            mismatches++;
            final_report();
        end
    end
    initial
    begin
        reset_check();
        foreach (rows[i])
        begin
            @(posedge clk);
            c1 <= rows[i].c1;
            c2 <= rows[i].c2;
            lin <= rows[i].lin;
            en <= rows[i].en;
            arm <= rows[i].arm;
            cut <= rows[i].cut;
            stb <= 1'b1;
            @(posedge clk);
            stb <= 1'b0;
            #1;
            chk("sample", rows[i].exp, smp);
            chk("ready", rows[i].rdy, rdy);
            chk("valid", rows[i].vld, vld);
            if (rows[i].vld)
                chk("pcm", rows[i].exp, pcm);
        end
        u_lsf_host_model.xfer(8'hC3, 4, 0, rd);
        chk("loop read", 32'h1B84_B30E, rd);
        u_lsf_host_model.xfer(8'hCD, 2, 0, rd);
        chk("sample read", 32'hAB00, rd);
        tbm <= 1'b1;
        u_lsf_host_model.xfer(8'hCD, 2, 0, rd);
        chk("buffer mode read", 32'h0000, rd);
        u_lsf_host_model.xfer(8'hC2, 4, 32'h25D3_4A15, rd);
        chk("loop fields", 32'h25D3_4A15,
            loop_w);
        u_lsf_host_model.xfer(8'hC3, 4, 0, rd);
        chk("loop readback", 32'h25D3_4A15, rd);
        u_lsf_host_model.xfer(8'hC6, 2, 32'h7ACB, rd);
        chk("feed fields", 32'h7ACB,
            feed_w);
        u_lsf_host_model.xfer(8'hC6, 1, 32'h11, rd);
        chk("feed before last byte", 32'h7ACB, feed_w);
        // a lone byte completes the pending write; the next is a command
        u_lsf_host_model.xfer(8'h55, 0, 0, rd);
        chk("feed split write", 32'h1155, feed_w);
        u_lsf_host_model.xfer(8'h55, 0, 0, rd);
        u_lsf_host_model.xfer(8'hC7, 2, 0, rd);
        chk("feed after unknown command", 32'h1155, rd);
        u_lsf_host_model.xfer(8'hCA, 1, 32'h80, rd);
        u_lsf_host_model.xfer(8'hCB, 1, 0, rd);
        chk("gain readback", 32'h80, rd);
        chk("gain field", 32'h80, gain);
        reset_check();
        final_report();
    end
endmodule : testbench
bind lsf_line_supervision_feed_regs lsf_checker u_lsf_checker (
    .i_ref_clk, .i_rst_n, .i_mpi_cs_n, .i_ch1_sample, .i_ch2_sample,
    .i_sample_strobe, .i_linear_mode, .i_channel_enable,
    .i_transmit_interrupt_arm, .i_cut_transmit_path, .o_mpi_dout_oe_n,
    .o_offhook_debounce, .o_impedance_scaling_gain, .o_transmit_sample,
    .o_data_ready_flag, .o_pcm_transmit_output, .o_pcm_transmit_valid);
